// ==== rtl/psd_event_flag.sv ====
/*
 * One sticky event flag, cleared by a read of its register.
 * Assumes set and clear are single-cycle pulses on the system clock.
 */
`timescale 1ns/10ps
module psd_event_flag (
    input  wire logic clk_sys_i,   // System clock
    input  wire logic rst_b_i,     // Async reset, active low
    input  wire logic set_i,       // Event pulse
    input  wire logic clr_i,       // Read clear pulse
    output logic      flag_o       // Sticky flag
);
    // Set wins over a clear arriving in the same cycle
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flag_o <= 1'b0;
        end else begin
            flag_o <= set_i | (flag_o & ~clr_i);
        end
    end
endmodule // psd_event_flag

// ==== rtl/psd_mdio_serial.sv ====
/*
 * Management serial frame engine: preamble, start, opcode, addresses, turnaround, data.
 * Assumes the management clock and data arrive synchronous to the system clock.
 */
`timescale 1ns/10ps
module psd_mdio_serial
    import psd_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = 5'h00
) (
    input  wire logic clk_sys_i,    // System clock
    input  wire logic rst_b_i,      // Async reset, active low
    input  wire logic mdc_i,        // Management clock, sampled
    input  wire logic mdio_i,       // Management data in
    output logic      mdio_o,       // Management data out
    output logic      mdio_oe_o,    // Management data drive enable
    psd_regif_if.serial bus         // Register access
);
    psd_ser_state_t state_reg;
    logic        mdc_q;
    logic        rise;
    logic [5:0]  ones_reg;
    logic [4:0]  cnt_reg;
    logic [15:0] sh_reg;
    logic [15:0] rsh_reg;
    logic        is_rd_reg;
    logic        sel_reg;
    logic [15:0] sh_next;
    logic [4:0]  addr_reg;

    assign rise    = mdc_i & ~mdc_q;
    assign sh_next = {sh_reg[14:0], mdio_i};
    assign bus.addr   = addr_reg;
    assign bus.wdata  = sh_next;
    // Read taken on first turnaround edge, write on last data edge
    assign bus.rd_stb = rise & (state_reg == PSD_S_TA) & (cnt_reg == 5'h00) & is_rd_reg & sel_reg;
    assign bus.wr_stb = rise & (state_reg == PSD_S_DATA) & (cnt_reg == PSD_DATA_BITS - 5'h01)
                        & ~is_rd_reg & sel_reg;

    // Management clock edge detect
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) mdc_q <= 1'b0;
        else          mdc_q <= mdc_i;
    end

    // Frame sequencer
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= PSD_S_PRE;
            ones_reg  <= 6'h00;
            cnt_reg   <= 5'h00;
            sh_reg    <= 16'h0000;
            rsh_reg   <= 16'h0000;
            is_rd_reg <= 1'b0;
            sel_reg   <= 1'b0;
            addr_reg  <= 5'h00;
            mdio_o    <= 1'b0;
            mdio_oe_o <= 1'b0;
        end else if (rise) begin
            sh_reg  <= sh_next;
            cnt_reg <= cnt_reg + 5'h01;
            case (state_reg)
                PSD_S_PRE: begin
                    if (mdio_i) begin
                        if (ones_reg != PSD_PREAMBLE_LEN) ones_reg <= ones_reg + 6'h01;
                    end else if (ones_reg == PSD_PREAMBLE_LEN) begin
                        state_reg <= PSD_S_ST;
                    end else begin
                        ones_reg <= 6'h00;
                    end
                end
                PSD_S_ST: begin
                    ones_reg  <= 6'h00;
                    cnt_reg   <= 5'h00;
                    state_reg <= mdio_i ? PSD_S_OP : PSD_S_PRE;
                end
                PSD_S_OP: begin
                    if (cnt_reg == 5'h01) begin
                        cnt_reg   <= 5'h00;
                        is_rd_reg <= (sh_next[1:0] == PSD_OP_READ);
                        state_reg <= (sh_next[1:0] == PSD_OP_READ ||
                                      sh_next[1:0] == PSD_OP_WRITE) ? PSD_S_ADR : PSD_S_PRE;
                    end
                end
                PSD_S_ADR: begin
                    if (cnt_reg == PSD_ADR_BITS - 5'h01) begin
                        cnt_reg   <= 5'h00;
                        sel_reg   <= (sh_next[9:5] == PHY_ADDR);
                        addr_reg  <= sh_next[4:0];
                        state_reg <= PSD_S_TA;
                    end
                end
                PSD_S_TA: begin
                    if (cnt_reg == 5'h00) begin
                        rsh_reg <= bus.rdata;
                        if (is_rd_reg && sel_reg) begin
                            mdio_oe_o <= 1'b1;
                            mdio_o    <= 1'b0;
                        end
                    end else begin
                        cnt_reg   <= 5'h00;
                        state_reg <= PSD_S_DATA;
                        mdio_o    <= rsh_reg[15];
                        rsh_reg   <= {rsh_reg[14:0], 1'b0};
                    end
                end
                PSD_S_DATA: begin
                    mdio_o  <= rsh_reg[15];
                    rsh_reg <= {rsh_reg[14:0], 1'b0};
                    if (cnt_reg == PSD_DATA_BITS - 5'h01) begin
                        mdio_oe_o <= 1'b0;
                        mdio_o    <= 1'b0;
                        ones_reg  <= 6'h00;
                        state_reg <= PSD_S_PRE;
                    end
                end
                default: state_reg <= PSD_S_PRE;
            endcase
        end
    end
endmodule // psd_mdio_serial

// ==== rtl/psd_pkg.sv ====
/*
 * Constants for the transceiver status, event and cable diagnostic register bank.
 * Assumes a single system clock and a management serial frame of standard layout.
 */
package psd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [4:0] PSD_OFS_INT_CTRL_STAT = 5'h1B;
    localparam logic [4:0] PSD_OFS_CABLE_DIAG    = 5'h1D;
    localparam logic [4:0] PSD_OFS_PHY_CTRL_ONE  = 5'h1E;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int PSD_EVT_NUM       = 4;
    localparam int PSD_BIT_ENABLE_LO = 8;
    localparam int PSD_BIT_TEST_EN   = 15;
    localparam int PSD_BIT_RES_LO    = 13;
    localparam int PSD_BIT_SHORT     = 12;
    localparam int PSD_BIT_DRSV_LO   = 9;
    localparam int PSD_BIT_PAUSE     = 9;
    localparam int PSD_BIT_LINK      = 8;
    localparam int PSD_BIT_POLARITY  = 7;
    localparam int PSD_BIT_MDIX      = 5;
    localparam int PSD_BIT_ENERGY    = 4;
    localparam int PSD_BIT_ISOLATE   = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and codes
    localparam logic [7:0]  PSD_RST_ENABLES  = 8'h00;
    localparam logic [2:0]  PSD_RST_DRSV     = 3'h0;
    localparam logic [1:0]  PSD_RES_NORMAL   = 2'h0;
    localparam logic [8:0]  PSD_RST_DIST     = 9'h000;
    localparam logic [2:0]  PSD_MODE_NEGOT   = 3'h0;
    localparam logic [15:0] PSD_READ_UNMAP   = 16'hFFFF;

    ////////////////////////////////////////////////////////////////////////////
    // Serial management frame
    localparam logic [5:0] PSD_PREAMBLE_LEN = 6'h20;
    localparam logic [1:0] PSD_OP_READ      = 2'h2;
    localparam logic [1:0] PSD_OP_WRITE     = 2'h1;
    localparam logic [4:0] PSD_ADR_BITS     = 5'h0A;
    localparam logic [4:0] PSD_DATA_BITS    = 5'h10;

    typedef enum logic [2:0] {
        PSD_S_PRE  = 3'h0,
        PSD_S_ST   = 3'h1,
        PSD_S_OP   = 3'h2,
        PSD_S_ADR  = 3'h3,
        PSD_S_TA   = 3'h4,
        PSD_S_DATA = 3'h5
    } psd_ser_state_t;

endpackage

// ==== rtl/psd_regif_if.sv ====
/*
 * Register access carrier between the serial frame engine and the register bank.
 * Assumes strobes are single-cycle and read data is combinational from the bank.
 */
`timescale 1ns/10ps
interface psd_regif_if;
    logic        rd_stb;    // Read of addr taken this cycle
    logic        wr_stb;    // Write of wdata to addr this cycle
    logic [4:0]  addr;      // Register offset
    logic [15:0] wdata;     // Write data
    logic [15:0] rdata;     // Read data for addr

    modport serial (output rd_stb, output wr_stb, output addr, output wdata, input rdata);
    modport regs   (input rd_stb, input wr_stb, input addr, input wdata, output rdata);
endinterface // psd_regif_if

// ==== rtl/psd_regs.sv ====
/*
 * Transceiver status, event and cable diagnostic register bank behind the
 * management serial interface, with the interrupt pin.
 * Assumes all core status and event inputs are synchronous to clk_sys_i.
 */
`timescale 1ns/10ps
module psd_regs
    import psd_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = 5'h00
) (
    input  wire logic       clk_sys_i,       // System clock, 10 MHz
    input  wire logic       rst_b_i,         // Async reset, active low
    input  wire logic       mdc_i,           // Management clock
    input  wire logic       mdio_i,          // Management data in
    output logic            mdio_o,          // Management data out
    output logic            mdio_oe_o,       // Management data drive enable
    input  wire logic       lp_ack_i,        // Partner acknowledge pulse
    input  wire logic       rem_fault_i,     // Remote fault pulse
    input  wire logic       link_up_i,       // Current link state
    input  wire logic       pause_cap_i,     // Flow control capable
    input  wire logic       pol_rev_i,       // Receive polarity reversed
    input  wire logic       mdix_i,          // Crossover resolved to MDI-X
    input  wire logic       energy_i,        // Receive pair energy present
    input  wire logic [2:0] op_mode_i,       // Resolved operating mode
    input  wire logic       int_level_i,     // Interrupt pin active high
    input  wire logic       diag_done_i,     // Cable test finished pulse
    input  wire logic [1:0] diag_result_i,   // Cable test outcome
    input  wire logic       diag_short_i,    // Cable under ten meters
    input  wire logic [8:0] diag_dist_i,     // Distance to fault
    output logic            diag_start_o,    // Cable test start pulse
    output logic            isolate_o,       // Isolate mode
    output logic            int_o            // Interrupt pin
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration check

    if (PHY_ADDR > 5'h1F) begin : g_bad_addr
        $error("PHY_ADDR out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial engine

    psd_regif_if bus ();

    psd_mdio_serial #(
        .PHY_ADDR (PHY_ADDR)
    ) u_serial (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .mdc_i     (mdc_i),
        .mdio_i    (mdio_i),
        .mdio_o    (mdio_o),
        .mdio_oe_o (mdio_oe_o),
        .bus       (bus.serial)
    );

    // Decoded accesses
    logic wr_int;
    logic wr_diag;
    logic wr_ctrl;
    logic rd_int;

    assign wr_int  = bus.wr_stb & (bus.addr == PSD_OFS_INT_CTRL_STAT);
    assign wr_diag = bus.wr_stb & (bus.addr == PSD_OFS_CABLE_DIAG);
    assign wr_ctrl = bus.wr_stb & (bus.addr == PSD_OFS_PHY_CTRL_ONE);
    assign rd_int  = bus.rd_stb & (bus.addr == PSD_OFS_INT_CTRL_STAT);

    ////////////////////////////////////////////////////////////////////////////
    // Core status capture

    logic       pause_reg;
    logic       link_reg;
    logic       pol_reg;
    logic       mdix_reg;
    logic       energy_reg;
    logic [2:0] mode_reg;

    // Status inputs registered once; register reads see the captured copy
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pause_reg  <= 1'b0;
            link_reg   <= 1'b0;
            pol_reg    <= 1'b0;
            mdix_reg   <= 1'b0;
            energy_reg <= 1'b0;
            mode_reg   <= PSD_MODE_NEGOT;
        end else begin
            pause_reg  <= pause_cap_i;
            link_reg   <= link_up_i;
            pol_reg    <= pol_rev_i;
            mdix_reg   <= mdix_i;
            energy_reg <= energy_i;
            mode_reg   <= op_mode_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event flags

    logic [PSD_EVT_NUM-1:0] evt_set;
    logic [PSD_EVT_NUM-1:0] evt_flag;

    assign evt_set[0] = link_up_i & ~link_reg;
    assign evt_set[1] = rem_fault_i;
    assign evt_set[2] = ~link_up_i & link_reg;
    assign evt_set[3] = lp_ack_i;

    // flags clear on read of the status register
    for (genvar i = 0; i < PSD_EVT_NUM; i++) begin : g_evt
        psd_event_flag u_flag (
            .clk_sys_i (clk_sys_i),
            .rst_b_i   (rst_b_i),
            .set_i     (evt_set[i]),
            .clr_i     (rd_int),
            .flag_o    (evt_flag[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event enables

    logic [7:0] enable_reg;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            enable_reg <= PSD_RST_ENABLES;
        end else if (wr_int) begin
            enable_reg <= bus.wdata[PSD_BIT_ENABLE_LO+7:PSD_BIT_ENABLE_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt pin

    logic int_any;

    // any enabled flag asserts the pin, driving it high or low as int_level_i selects
    assign int_any = |(evt_flag & enable_reg[PSD_EVT_NUM-1:0]);

    // pin polarity from the level control; idle high at reset
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            int_o <= 1'b1;
        end else begin
            int_o <= int_level_i ? int_any : ~int_any;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cable diagnostic

    logic       test_en_reg;
    logic [1:0] result_reg;
    logic       short_reg;
    logic [2:0] drsv_reg;
    logic [8:0] dist_reg;
    logic       start_req;

    // A new test starts only when none is running
    assign start_req = wr_diag & bus.wdata[PSD_BIT_TEST_EN] & ~test_en_reg;

    // test enable set by software, self-cleared on completion
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            test_en_reg <= 1'b0;
        end else if (start_req) begin
            test_en_reg <= 1'b1;
        end else if (diag_done_i) begin
            test_en_reg <= 1'b0;
        end
    end

    // One-cycle start pulse to the analog test engine
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            diag_start_o <= 1'b0;
        end else begin
            diag_start_o <= start_req;
        end
    end

    // results loaded in the same edge that clears test enable
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            result_reg <= PSD_RES_NORMAL;
            short_reg  <= 1'b0;
            dist_reg   <= PSD_RST_DIST;
        end else if (diag_done_i && test_en_reg) begin
            result_reg <= diag_result_i;
            short_reg  <= diag_short_i;
            dist_reg   <= diag_dist_i;
        end
    end

    // Reserved read/write bits keep their written value
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            drsv_reg <= PSD_RST_DRSV;
        end else if (wr_diag) begin
            drsv_reg <= bus.wdata[PSD_BIT_TEST_EN-4:PSD_BIT_DRSV_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Isolate control

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            isolate_o <= 1'b0;
        end else if (wr_ctrl) begin
            isolate_o <= bus.wdata[PSD_BIT_ISOLATE];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data

    logic [15:0] int_word;
    logic [15:0] diag_word;
    logic [15:0] ctrl_word;

    // Status word: enables above, four flags below, upper flags read zero
    always_comb begin
        int_word = 16'h0000;
        int_word[PSD_BIT_ENABLE_LO+7:PSD_BIT_ENABLE_LO] = enable_reg;
        int_word[PSD_EVT_NUM-1:0] = evt_flag;
    end

    // Cable diagnostic word
    always_comb begin
        diag_word = 16'h0000;
        diag_word[PSD_BIT_TEST_EN] = test_en_reg;
        diag_word[PSD_BIT_RES_LO+1:PSD_BIT_RES_LO] = result_reg;
        diag_word[PSD_BIT_SHORT] = short_reg;
        diag_word[PSD_BIT_TEST_EN-4:PSD_BIT_DRSV_LO] = drsv_reg;
        diag_word[8:0] = dist_reg;
    end

    // Control one word; reserved bits read zero
    always_comb begin
        ctrl_word = 16'h0000;
        ctrl_word[PSD_BIT_PAUSE]    = pause_reg;
        ctrl_word[PSD_BIT_LINK]     = link_reg;
        ctrl_word[PSD_BIT_POLARITY] = pol_reg;
        ctrl_word[PSD_BIT_MDIX]     = mdix_reg;
        ctrl_word[PSD_BIT_ENERGY]   = energy_reg;
        ctrl_word[PSD_BIT_ISOLATE]  = isolate_o;
        ctrl_word[2:0]              = mode_reg;
    end

    // Register select; offsets outside this bank read all ones
    always_comb begin
        case (bus.addr)
            PSD_OFS_INT_CTRL_STAT: bus.rdata = int_word;
            PSD_OFS_CABLE_DIAG:    bus.rdata = diag_word;
            PSD_OFS_PHY_CTRL_ONE:  bus.rdata = ctrl_word;
            default:               bus.rdata = PSD_READ_UNMAP;
        endcase
    end

endmodule // psd_regs

// ==== verification/psd_mgmt_model.sv ====
/* Station management controller model sending whole frames.
   Assumes the bench resolves the line with a pull-up. */
`timescale 1ns/10ps
module psd_mgmt_model
    import psd_pkg::*;
(
    input  wire logic clk_sys_i, // System clock
    input  wire logic mdio_i,    // Resolved line
    output logic      mdc_o,     // Management clock
    output logic      mdio_o,    // Controller data
    output logic      mdio_oe_o  // Controller drives line
);
    // Idle: clock still, line released
    initial begin
        mdc_o     = 1'b0;
        mdio_o    = 1'b1;
        mdio_oe_o = 1'b0;
    end
    // One bit, two clocks low then two high; sample ends the low phase
    task automatic bit_cyc(input logic oe, input logic d, output logic s);
        @(negedge clk_sys_i);
        mdc_o     <= 1'b0;
        mdio_oe_o <= oe;
        mdio_o    <= d;
        repeat (2) @(negedge clk_sys_i);
        s = mdio_i;
        mdc_o <= 1'b1;
        @(negedge clk_sys_i);
    endtask
    // Frame with fresh preamble; line released from turnaround on reads
    task automatic frame(input logic [4:0] phy, input logic rd, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] q);
        logic [63:0] w;
        logic        s;
        w = {32'hFFFF_FFFF, 2'h1, rd ? PSD_OP_READ : PSD_OP_WRITE, phy, ra, 2'h2, wd};
        for (int i = 63; i >= 0; i--) begin
            bit_cyc(!rd || i > 17, w[i], s);
            if (i < 16) q[i] = s;
        end
        repeat (2) @(negedge clk_sys_i);
        mdio_oe_o <= 1'b0;
    endtask
endmodule // psd_mgmt_model

// ==== verification/psd_regs_checker.sv ====
/* Port checker for psd_regs, bound to the bank.
   Assumes mdc_i stays high and low two clocks each. */
`timescale 1ns/10ps
module psd_regs_checker (
    input  wire logic clk_sys_i,    // Clock
    input  wire logic rst_b_i,      // Reset
    input  wire logic mdc_i,        // Mgmt clock
    input  wire logic mdio_o,       // Data out
    input  wire logic mdio_oe_o,    // Drive enable
    input  wire logic int_level_i,  // Pin level
    input  wire logic diag_done_i,  // Test done
    input  wire logic diag_start_o, // Test start
    input  wire logic isolate_o,    // Isolate
    input  wire logic int_o         // Interrupt
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    logic       mdc_reg, run_reg;
    logic [4:0] oe_cnt_reg;
    // Clock history, test running, rises seen while driving
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mdc_reg    <= 1'b0;
            run_reg    <= 1'b0;
            oe_cnt_reg <= 5'h00;
        end else begin
            mdc_reg    <= mdc_i;
            run_reg    <= diag_start_o | (run_reg & !diag_done_i);
            oe_cnt_reg <= mdio_oe_o ? oe_cnt_reg + 5'(mdc_i & !mdc_reg) : 5'h00;
        end
    end
    a_start_one_cycle: assert property (diag_start_o |=> !diag_start_o)
        else $error("start pulse too long");
    a_start_idle_only: assert property (diag_start_o |-> !run_reg)
        else $error("start while test running");
    a_start_on_write: assert property ($rose(diag_start_o) |-> $past(mdc_i))
        else $error("start not after a frame bit");
    a_iso_on_write: assert property ($changed(isolate_o) |-> $past(mdc_i))
        else $error("isolate moved outside a write");
    a_oe_after_rise: assert property ($rose(mdio_oe_o) |-> $past(mdc_i) && !mdio_o)
        else $error("drive began badly");
    a_data_on_rise: assert property (mdio_oe_o && $changed(mdio_o) |-> $past(mdc_i))
        else $error("data moved between rises");
    a_drive_span: assert property ($fell(mdio_oe_o) |-> oe_cnt_reg == 5'h11)
        else $error("read drive span wrong");
    a_int_after_reset: assert property ($rose(rst_b_i) |=> int_o == !int_level_i)
        else $error("interrupt active after reset");
    c_start: cover property (diag_start_o);
    c_read: cover property ($fell(mdio_oe_o));
    c_int: cover property (int_o == int_level_i);
endmodule // psd_regs_checker
bind psd_regs psd_regs_checker chk (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .mdc_i(mdc_i), .mdio_o(mdio_o),
    .mdio_oe_o(mdio_oe_o), .int_level_i(int_level_i), .diag_done_i(diag_done_i),
    .diag_start_o(diag_start_o), .isolate_o(isolate_o), .int_o(int_o));

// ==== verification/test_phy_status_diag_registers.sv ====
/* Self-checking bench for psd_regs driven by a management controller model.
   Assumes a 10 MHz clock; inputs change on the falling edge. */
`timescale 1ns/10ps
module test_phy_status_diag_registers
    import psd_pkg::*;
;
    localparam logic [4:0] PHY = 5'h03;
    localparam logic [4:0] IS = PSD_OFS_INT_CTRL_STAT;
    localparam logic [4:0] CD = PSD_OFS_CABLE_DIAG;
    localparam logic [4:0] P1 = PSD_OFS_PHY_CTRL_ONE;
    logic        clk_sys_i, rst_b_i, mdc, m_dat, m_oe, line, mdio_o, mdio_oe_o;
    logic        lp_ack, rem_fault, link_up, pause_cap, pol_rev, mdix, energy, int_level;
    logic        diag_done, diag_start_o, isolate_o, int_o, iso;
    logic [2:0]  op_mode;
    logic [11:0] dval;
    logic [15:0] q, e, prev;
    int          n_errors, tests_run, n_start;
    // Line with pull-up when nobody drives
    assign line = mdio_oe_o ? mdio_o : (m_oe ? m_dat : 1'b1);
    psd_regs #(.PHY_ADDR(PHY)) uut (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .mdc_i(mdc), .mdio_i(line),
        .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .lp_ack_i(lp_ack), .rem_fault_i(rem_fault),
        .link_up_i(link_up), .pause_cap_i(pause_cap), .pol_rev_i(pol_rev), .mdix_i(mdix),
        .energy_i(energy), .op_mode_i(op_mode), .int_level_i(int_level),
        .diag_done_i(diag_done), .diag_result_i(dval[11:10]), .diag_short_i(dval[9]),
        .diag_dist_i(dval[8:0]), .diag_start_o(diag_start_o), .isolate_o(isolate_o),
        .int_o(int_o));
    psd_mgmt_model mm (.clk_sys_i(clk_sys_i), .mdio_i(line), .mdc_o(mdc), .mdio_o(m_dat),
                       .mdio_oe_o(m_oe));
    ////////////////////////////////
    // Clock, start counter, watchdog
    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) if (diag_start_o === 1'b1) n_start++;
    initial begin
        #(100 * 40000);
        n_errors++;
        stop_test();
    end
    ////////////////////////////////
    // Helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [4:0] ra, input logic [15:0] x);
        logic [15:0] d;
        mm.frame(PHY, 1'b1, ra, 16'h0000, d);
        check(d, x);
    endtask
    task automatic wr(input logic [4:0] ra, input logic [15:0] x);
        mm.frame(PHY, 1'b0, ra, x, q);
    endtask
    // Event k sets status bit k
    task automatic pulse(input int k);
        @(negedge clk_sys_i);
        case (k)
            0: link_up = 1'b1;
            1: rem_fault = 1'b1;
            2: link_up = 1'b0;
            default: lp_ack = 1'b1;
        endcase
        @(negedge clk_sys_i);
        {rem_fault, lp_ack} = 2'h0;
    endtask
    task automatic done_pulse(input logic [11:0] v);
        @(negedge clk_sys_i);
        dval      = v;
        diag_done = 1'b1;
        @(negedge clk_sys_i);
        diag_done = 1'b0;
    endtask
    function automatic logic [15:0] exp_1e();
        return {6'h00, pause_cap, link_up, pol_rev, 1'b0, mdix, energy, iso, op_mode};
    endfunction
    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////
    // Main sequence
    initial begin
        {lp_ack, rem_fault, link_up, pause_cap, pol_rev, mdix, energy, int_level} = 8'h00;
        {diag_done, iso, op_mode, dval, prev} = 33'h0;
        {n_errors, tests_run, n_start} = {32'h0, 32'h0, 32'h0};
        rst_b_i = 1'b0;
        void'($urandom(29320));
        repeat (20) @(negedge clk_sys_i);
        rst_b_i = 1'b1;
        check({14'h0, isolate_o, int_o}, 16'h0001);
        rchk(IS, 16'h0000);
        rchk(CD, 16'h0000);
        rchk(P1, 16'h0000);
        for (int n = 0; n < 8; n++) begin
            @(negedge clk_sys_i);
            {pause_cap, link_up, pol_rev, mdix, energy} = 5'($urandom);
            op_mode = 3'(n);
            rchk(P1, exp_1e());
        end
        for (int n = 1; n >= 0; n--) begin
            wr(P1, n ? 16'hFFFF : 16'h0000);
            iso = 1'(n);
            check({15'h0, isolate_o}, {15'h0, iso});
            rchk(P1, exp_1e());
        end
        @(negedge clk_sys_i);
        link_up = 1'b0;
        mm.frame(PHY, 1'b1, IS, 16'h0000, q);
        wr(IS, 16'hFF0F);
        rchk(IS, 16'hFF00);
        for (int k = 0; k < 4; k++) begin
            int_level = 1'($urandom);
            repeat (3) @(negedge clk_sys_i);
            pulse(k);
            repeat (2) @(negedge clk_sys_i);
            check({15'h0, int_o}, {15'h0, int_level});
            rchk(IS, 16'hFF00 | (16'h0001 << k));
            rchk(IS, 16'hFF00);
            check({15'h0, int_o}, {15'h0, ~int_level});
        end
        wr(IS, 16'h0000);
        pulse(1);
        repeat (2) @(negedge clk_sys_i);
        check({15'h0, int_o}, {15'h0, ~int_level});
        rchk(IS, 16'h0002);
        for (int r = 0; r < 4; r++) begin
            e = {1'b0, 2'(r), 13'($urandom)};
            wr(CD, {4'h8, e[11:9], 9'h000});
            // Second write: restart ignored, a zero does not abort
            wr(CD, {r[0], 3'h0, e[11:9], 9'h000});
            check(16'(n_start), 16'(r + 1));
            rchk(CD, {1'b1, prev[14:12], e[11:9], prev[8:0]});
            done_pulse({e[14:12], e[8:0]});
            done_pulse(12'($urandom));
            rchk(CD, e);
            prev = e;
        end
        // Unmapped offset, other address
        rchk(5'h1C, PSD_READ_UNMAP);
        mm.frame(PHY + 5'h01, 1'b1, IS, 16'h0000, q);
        check(q, 16'hFFFF);
        stop_test();
    end
endmodule // test_phy_status_diag_registers
